// file: rtl/hcr_pkg.sv
// package of register offsets, field positions, reset values and timing counts
package hcr_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CAL_BURN_CTRL  = 8'h1e;
    localparam logic [7:0] ADDR_SUPPLY_MON     = 8'h21;
    localparam logic [7:0] ADDR_RES_PERIOD     = 8'h22;
    localparam logic [7:0] ADDR_WAVE_PTR_HIGH  = 8'hfd;
    localparam logic [7:0] ADDR_WAVE_PTR_LOW   = 8'hfe;
    localparam logic [7:0] ADDR_WAVE_WR_PORT   = 8'hff;
    localparam logic [7:0] ADDR_BURN_FIRST     = 8'h16;
    localparam logic [7:0] ADDR_BURN_LAST      = 8'h1a;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int         CAL_TIME_LSB        = 4;
    localparam int         NV_STATUS_BIT       = 2;
    localparam int         NV_PROGRAM_BIT      = 0;
    localparam logic [1:0] CAL_TIME_RESET      = 2'h2;
    localparam logic [7:0] BYTE_RESET          = 8'h00;

    // ----------------------------------------------------------------
    // timing: calibration run length per code, minimum and maximum in ms
    // ----------------------------------------------------------------
    localparam int CLK_KHZ        = 250000;
    localparam int CAL0_MIN_MS    = 150;
    localparam int CAL0_MAX_MS    = 350;
    localparam int CAL1_MIN_MS    = 250;
    localparam int CAL1_MAX_MS    = 450;
    localparam int CAL2_MIN_MS    = 500;
    localparam int CAL2_MAX_MS    = 700;
    localparam int CAL3_MIN_MS    = 1000;
    localparam int CAL3_MAX_MS    = 1200;
    // target the midpoint of each window
    localparam int CAL0_CYCLES    = (CAL0_MIN_MS + CAL0_MAX_MS) / 2 * CLK_KHZ;
    localparam int CAL1_CYCLES    = (CAL1_MIN_MS + CAL1_MAX_MS) / 2 * CLK_KHZ;
    localparam int CAL2_CYCLES    = (CAL2_MIN_MS + CAL2_MAX_MS) / 2 * CLK_KHZ;
    localparam int CAL3_CYCLES    = (CAL3_MIN_MS + CAL3_MAX_MS) / 2 * CLK_KHZ;

    // ----------------------------------------------------------------
    // scaling of read-backs: supply mv full scale, period step in 10 ns units
    // ----------------------------------------------------------------
    localparam int SUPPLY_FULL_MV = 5600;
    localparam int SUPPLY_CODES   = 255;
    localparam int PERIOD_STEP_10NS = 9846;

    typedef enum logic [1:0] {
        HCR_BURN_IDLE = 2'b00,
        HCR_BURN_COPY = 2'b01,
        HCR_BURN_DONE = 2'b10
    } hcr_burn_state_t;
endpackage

// file: rtl/hcr_nv_mem.sv
// five-byte one-time-programmable store with registered read data
`timescale 1ns/1ns
`default_nettype none
module hcr_nv_mem #(
    parameter int DEPTH = 5
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input  wire logic [7:0]               i_wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
    output var  logic [7:0]               o_rd_data
);
    logic [7:0] mem [DEPTH];

    // storage cells have no reset, like fuses before a burn
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
    end

    // registered read port
    always_ff @(posedge i_clk) begin
        o_rd_data <= mem[i_rd_addr];
    end
endmodule
`default_nettype wire

// file: rtl/hcr_regs.sv
// register slice: calibration time, burn control, monitors, waveform pointer
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RULE1] two-bit code selects calibration run length
// [RULE2] host picks duration long enough to settle
// [RULE3] status bit reads one once burned
// [RULE4] program bit copies config 0x16..0x1a to store
// [RULE5] burn allowed once; later requests ignored
// [RULE6] supply reading updates only during playback; code also takes host writes to 0x21 outside playback
// [RULE7] supply volts equal code times 5.6/255
// [RULE8] period reading valid only during playback
// [RULE9] each period count is 98.46 us
// [RULE10] 0xfd holds pointer high byte, resets zero
// [RULE11] 0xfe holds pointer low byte, resets zero
// [RULE12] ram data writes store then auto-increment
// [RULE13] reserved control bits read zero, ignore writes
module hcr_regs #(
    parameter int CYCLES_PER_MS = hcr_pkg::CLK_KHZ
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // register access from the serial-bus front end, same clock
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output var  logic [7:0]  o_reg_rdata,
    output var  logic        o_reg_rvalid,
    // configuration bytes 0x16..0x1a held elsewhere, read for the burn
    output var  logic [7:0]  o_cfg_addr,
    input  wire logic [7:0]  i_cfg_data,
    // playback engine measurements
    input  wire logic        i_playing,
    input  wire logic [7:0]  i_supply_code,
    input  wire logic [7:0]  i_period_code,
    // calibration engine
    input  wire logic        i_cal_start,
    output var  logic        o_cal_busy,
    // waveform ram write port and burn busy flag
    output var  logic        o_wave_we,
    output var  logic [15:0] o_wave_addr,
    output var  logic [7:0]  o_wave_data,
    output var  logic        o_nv_busy
);
    import hcr_pkg::*;

    // ----------------------------------------------------------------
    // calibration duration
    // ----------------------------------------------------------------
    logic [1:0]  cal_time;
    logic [31:0] cal_count;

    // package counts assume the nominal clock; rescaled to the tick rate in use
    function automatic logic [31:0] cal_len(input logic [1:0] code);
        case (code)
            2'h0:    cal_len = 32'(CAL0_CYCLES / CLK_KHZ * CYCLES_PER_MS);
            2'h1:    cal_len = 32'(CAL1_CYCLES / CLK_KHZ * CYCLES_PER_MS);
            2'h2:    cal_len = 32'(CAL2_CYCLES / CLK_KHZ * CYCLES_PER_MS);
            default: cal_len = 32'(CAL3_CYCLES / CLK_KHZ * CYCLES_PER_MS);
        endcase
    endfunction

    logic wr_ctrl;
    assign wr_ctrl = i_reg_wr && (i_reg_addr == ADDR_CAL_BURN_CTRL);

    // only the duration field is stored, reserved bits dropped
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cal_time <= CAL_TIME_RESET;
        end else if (wr_ctrl) begin
            cal_time <= i_reg_wdata[CAL_TIME_LSB +: 2];   // [RULE13]
        end
    end

    // run-length timer; field sampled at start so a rewrite mid-run is harmless
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cal_count  <= '0;
            o_cal_busy <= 1'b0;
        end else if (i_cal_start && !o_cal_busy) begin
            cal_count  <= cal_len(cal_time) - 32'h1;  // [RULE1]
            o_cal_busy <= 1'b1;
        end else if (o_cal_busy) begin
            cal_count  <= cal_count - 32'h1;
            o_cal_busy <= (cal_count != 32'h0);
        end
    end

    // ----------------------------------------------------------------
    // one-time burn
    // ----------------------------------------------------------------
    hcr_burn_state_t burn_state;
    logic            burned;
    logic [2:0]      burn_idx;
    logic            burn_req;
    logic            nv_we;

    assign burn_req = wr_ctrl && i_reg_wdata[NV_PROGRAM_BIT];

    // once burned, further launches are ignored
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            burn_state <= HCR_BURN_IDLE;
            burn_idx   <= 3'h0;
            o_cfg_addr <= ADDR_BURN_FIRST;
            burned     <= 1'b0;
        end else begin
            case (burn_state)
                HCR_BURN_IDLE: begin
                    if (burn_req && !burned) begin        // [RULE5]
                        burn_state <= HCR_BURN_COPY;
                        burn_idx   <= 3'h0;
                        o_cfg_addr <= ADDR_BURN_FIRST;
                    end
                end
                HCR_BURN_COPY: begin
                    burn_idx   <= burn_idx + 3'h1;        // [RULE4]
                    o_cfg_addr <= o_cfg_addr + 8'h1;      // [RULE4]
                    if (o_cfg_addr == ADDR_BURN_LAST) begin
                        burn_state <= HCR_BURN_DONE;
                    end
                end
                HCR_BURN_DONE: begin
                    burned     <= 1'b1;                   // [RULE3]
                    burn_state <= HCR_BURN_IDLE;
                end
                default: burn_state <= HCR_BURN_IDLE;
            endcase
        end
    end

    // config address is registered in step with the index; data arrives same cycle
    always_comb begin
        nv_we = (burn_state == HCR_BURN_COPY);            // [RULE4]
    end

    hcr_nv_mem #(
        .DEPTH (5)
    ) u_nv_mem (
        .i_clk     (i_clk),
        .i_wr_en   (nv_we),
        .i_wr_addr (burn_idx),
        .i_wr_data (i_cfg_data),
        .i_rd_addr (burn_idx),
        .o_rd_data ()
    );

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_nv_busy <= 1'b0;
        end else begin
            o_nv_busy <= (burn_state != HCR_BURN_IDLE) || (burn_req && !burned);
        end
    end

    // ----------------------------------------------------------------
    // playback read-backs
    // ----------------------------------------------------------------
    logic [7:0] supply_code;
    logic [7:0] resonance_period_code;

    // held between waveforms unless the host writes 0x21 or 0x22; codes scale as 5.6 V / 255 and 98.46 us per count
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            supply_code           <= BYTE_RESET;
            resonance_period_code <= BYTE_RESET;
        end else if (i_playing) begin
            supply_code           <= i_supply_code;  // [RULE6] [RULE7]
            resonance_period_code <= i_period_code;  // [RULE8] [RULE9]
        end else begin
            if (i_reg_wr && i_reg_addr == ADDR_SUPPLY_MON) begin
                supply_code <= i_reg_wdata;
            end
            if (i_reg_wr && i_reg_addr == ADDR_RES_PERIOD) begin
                resonance_period_code <= i_reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // waveform ram pointer and data port
    // ----------------------------------------------------------------
    logic [7:0] wave_pointer_high;
    logic [7:0] wave_pointer_low;
    logic       wr_data_port;

    assign wr_data_port = i_reg_wr && (i_reg_addr == ADDR_WAVE_WR_PORT);

    // pointer written directly or bumped after every data byte
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wave_pointer_high <= BYTE_RESET;             // [RULE10]
            wave_pointer_low  <= BYTE_RESET;             // [RULE11]
        end else if (wr_data_port) begin
            {wave_pointer_high, wave_pointer_low} <=
                {wave_pointer_high, wave_pointer_low} + 16'h1;  // [RULE12]
        end else if (i_reg_wr && i_reg_addr == ADDR_WAVE_PTR_HIGH) begin
            wave_pointer_high <= i_reg_wdata;            // [RULE10]
        end else if (i_reg_wr && i_reg_addr == ADDR_WAVE_PTR_LOW) begin
            wave_pointer_low  <= i_reg_wdata;            // [RULE11]
        end
    end

    // one write pulse per data byte at the pre-increment address
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_wave_we   <= 1'b0;
            o_wave_addr <= 16'h0;
            o_wave_data <= BYTE_RESET;
        end else begin
            o_wave_we <= wr_data_port;                   // [RULE12]
            if (wr_data_port) begin
                o_wave_addr <= {wave_pointer_high, wave_pointer_low};
                o_wave_data <= i_reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // read mux, one cycle latency; unmapped addresses read zero
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_reg_rdata  <= BYTE_RESET;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            case (i_reg_addr)
                ADDR_CAL_BURN_CTRL: o_reg_rdata <= {2'h0, cal_time, 1'b0, burned,
                                                    1'b0, 1'b0};  // [RULE3] [RULE13]
                ADDR_SUPPLY_MON:    o_reg_rdata <= supply_code;
                ADDR_RES_PERIOD:    o_reg_rdata <= resonance_period_code;
                ADDR_WAVE_PTR_HIGH: o_reg_rdata <= wave_pointer_high;
                ADDR_WAVE_PTR_LOW:  o_reg_rdata <= wave_pointer_low;
                default:            o_reg_rdata <= BYTE_RESET;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/hcr_cfg_model.sv
// configuration byte store standing in for registers 0x16..0x1a
`timescale 1ns/1ns
`default_nettype none
module hcr_cfg_model (
    input  wire logic [7:0] i_cfg_addr,
    output var  logic [7:0] o_cfg_data
);
    // -----------------------------------------------
    // same-cycle answer, pattern differs per byte
    // -----------------------------------------------
    always_comb begin
        o_cfg_data = i_cfg_addr ^ 8'ha5;
    end
endmodule
`default_nettype wire

// file: tb/hcr_regs_assertions.sv
// concurrent checks on the register slice ports
`timescale 1ns/1ns
`default_nettype none
module hcr_regs_assertions (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic [7:0]  o_cfg_addr,
    input wire logic        i_cal_start,
    input wire logic        o_cal_busy,
    input wire logic        o_wave_we,
    input wire logic [15:0] o_wave_addr,
    input wire logic [7:0]  o_wave_data,
    input wire logic        o_nv_busy
);
    import hcr_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic burned;
    // ---------------------------------
    // burn seen once, kept until reset
    // ---------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            burned <= 1'b0;
        end else if ($fell(o_nv_busy)) begin
            burned <= 1'b1;
        end
    end
    a_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read got no answer");
    a_wave_strobe: assert property (i_reg_wr && i_reg_addr == ADDR_WAVE_WR_PORT
        |=> o_wave_we && o_wave_data == $past(i_reg_wdata))
        else $error("ram byte not passed on");
    a_ptr_step: assert property (o_wave_we && $past(o_wave_we)
        |-> o_wave_addr == $past(o_wave_addr) + 16'h0001)
        else $error("pointer did not step");
    a_burn_start: assert property ($rose(o_nv_busy) |-> o_cfg_addr == ADDR_BURN_FIRST)
        else $error("burn did not start at first byte");
    a_burn_len: assert property ($rose(o_nv_busy) |-> o_nv_busy [*5])
        else $error("burn shorter than five bytes");
    a_burn_once: assert property (burned |-> !$rose(o_nv_busy))
        else $error("second burn started");
    a_ctrl_reserved: assert property (o_reg_rvalid && $past(i_reg_addr) == ADDR_CAL_BURN_CTRL
        |-> (o_reg_rdata & 8'hcb) == 8'h00)
        else $error("reserved control bits not zero");
    a_status_set: assert property (o_reg_rvalid && $past(i_reg_addr) == ADDR_CAL_BURN_CTRL
        && $past(burned) |-> o_reg_rdata[NV_STATUS_BIT])
        else $error("status bit low after burn");
    a_cal_run: assert property (i_cal_start && !o_cal_busy |-> ##1 o_cal_busy [*8])
        else $error("calibration run too short");
    // main scenarios reached
    c_burn: cover property ($rose(o_nv_busy));
    c_ram_burst: cover property (o_wave_we && $past(o_wave_we));
    c_cal: cover property ($rose(o_cal_busy));
endmodule
bind hcr_regs hcr_regs_assertions hcr_regs_assertions_inst (.*);
`default_nettype wire

// file: tb/hcr_regs_tb.sv
// self-checking bench for the register slice
`timescale 1ns/1ns
`default_nettype none
module hcr_regs_tb;
    import hcr_pkg::*;
    logic        i_clk = 0, i_resetn = 0, i_reg_wr = 0, i_reg_rd = 0;
    logic        i_playing = 0, i_cal_start = 0;
    logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_supply_code = 8'h00;
    logic [7:0]  i_period_code = 8'h00, i_cfg_data, o_reg_rdata, o_cfg_addr, o_wave_data;
    logic        o_reg_rvalid, o_cal_busy, o_wave_we, o_nv_busy;
    logic [15:0] o_wave_addr;
    int          fails = 0, checked = 0;
    // one tick per ms so every calibration code finishes inside the run
    localparam int MS_CYC = 1;
    always #2 i_clk = ~i_clk;
    hcr_regs #(.CYCLES_PER_MS(MS_CYC)) hcr_regs_inst (.*);
    hcr_cfg_model hcr_cfg_model_inst (.i_cfg_addr(o_cfg_addr), .o_cfg_data(i_cfg_data));
    // -----------------------------------------------
    // helpers: each drives at edge+1 and ends at edge+1
    // -----------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // strobes left up so bursts run back to back; idle drops them
    task automatic idle();
        i_reg_wr = 0;
        i_reg_rd = 0;
        @(posedge i_clk) #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_reg_rd = 0;
        i_reg_wr = 1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(posedge i_clk) #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_reg_wr = 0;
        i_reg_rd = 1;
        i_reg_addr = a;
        @(posedge i_clk) #1;
        chk(16'(o_reg_rvalid), 16'h0001);
        chk(16'(o_reg_rdata), 16'(exp));
    endtask
    // counts edges until the chosen busy flag drops; a hang ends the run
    task automatic wait_low(input bit cal, input int lim, output int n);
        n = 0;
        while ((cal ? o_cal_busy : o_nv_busy) !== 1'b0) begin
            if (n >= lim) begin
                fails++;
                $display("[ERR] %0t wait ran out", $time);
                tally_and_finish();
            end
            idle();
            n++;
        end
    endtask
    // -----------------------------------------------
    // scenarios
    // -----------------------------------------------
    task automatic t_reset_values();
        rd(ADDR_CAL_BURN_CTRL, {2'b00, CAL_TIME_RESET, 4'h0});
        rd(ADDR_WAVE_PTR_HIGH, BYTE_RESET);
        rd(ADDR_WAVE_PTR_LOW, BYTE_RESET);
        rd(ADDR_SUPPLY_MON, BYTE_RESET);
        rd(ADDR_RES_PERIOD, BYTE_RESET);
        idle();
        $display("test reset_values done");
    endtask
    task automatic t_pointer();
        wr(ADDR_WAVE_PTR_HIGH, 8'h12);
        wr(ADDR_WAVE_PTR_LOW, 8'hfe);
        rd(ADDR_WAVE_PTR_HIGH, 8'h12);
        rd(ADDR_WAVE_PTR_LOW, 8'hfe);
        // burst crosses the low byte boundary
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_WAVE_WR_PORT, 8'ha0 + 8'(i));
            chk(16'(o_wave_we), 16'h0001);
            chk(o_wave_addr, 16'h12fe + 16'(i));
            chk(16'(o_wave_data), 16'h00a0 + 16'(i));
        end
        idle();
        chk(16'(o_wave_we), 16'h0000);
        rd(ADDR_WAVE_PTR_LOW, 8'h01);
        rd(ADDR_WAVE_PTR_HIGH, 8'h13);
        idle();
        $display("test pointer done");
    endtask
    task automatic t_monitor();
        // 4.2 V supply and a 5.0215 ms period
        logic [7:0] sup, per;
        sup = 8'(4200 * SUPPLY_CODES / SUPPLY_FULL_MV);
        per = 8'(502150 / PERIOD_STEP_10NS);
        i_playing = 1;
        i_supply_code = sup;
        i_period_code = per;
        idle();
        idle();
        // host write during playback must not land
        wr(ADDR_SUPPLY_MON, ~sup);
        rd(ADDR_SUPPLY_MON, sup);
        rd(ADDR_RES_PERIOD, per);
        i_playing = 0;
        i_supply_code = ~sup;
        i_period_code = ~per;
        idle();
        idle();
        rd(ADDR_SUPPLY_MON, sup);
        rd(ADDR_RES_PERIOD, per);
        idle();
        $display("test monitor done");
    endtask
    task automatic t_control();
        int lo[4] = '{CAL0_MIN_MS, CAL1_MIN_MS, CAL2_MIN_MS, CAL3_MIN_MS};
        int hi[4] = '{CAL0_MAX_MS, CAL1_MAX_MS, CAL2_MAX_MS, CAL3_MAX_MS};
        int n;
        wr(ADDR_CAL_BURN_CTRL, 8'hfe);
        rd(ADDR_CAL_BURN_CTRL, 8'h30);
        // longest code chosen so the actuator settles
        i_cal_start = 1;
        idle();
        i_cal_start = 0;
        idle();
        repeat (10) begin
            chk(16'(o_cal_busy), 16'h0001);
            idle();
        end
        wait_low(1'b1, 2 * hi[3] * MS_CYC, n);
        // every code: run length must land inside its window
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CAL_BURN_CTRL, 8'(c << CAL_TIME_LSB));
            i_cal_start = 1;
            idle();
            i_cal_start = 0;
            wait_low(1'b1, hi[c] * MS_CYC + 8, n);
            chk(16'(n >= lo[c] * MS_CYC && n <= hi[c] * MS_CYC), 16'h0001);
        end
        $display("test control done");
    endtask
    task automatic t_burn();
        int n;
        wr(ADDR_CAL_BURN_CTRL, 8'h31);
        idle();
        chk(16'(o_nv_busy), 16'h0001);
        for (int i = 1; i < 5; i++) begin
            chk(16'(o_cfg_addr), 16'(ADDR_BURN_FIRST) + 16'(i));
            idle();
        end
        wait_low(1'b0, 50, n);
        rd(ADDR_CAL_BURN_CTRL, 8'h34);
        wr(ADDR_CAL_BURN_CTRL, 8'h31);
        idle();
        repeat (6) begin
            chk(16'(o_nv_busy), 16'h0000);
            idle();
        end
        $display("test burn done");
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        #1 i_resetn = 1;
        t_reset_values();
        t_pointer();
        t_monitor();
        t_control();
        t_burn();
        tally_and_finish();
    end
endmodule
`default_nettype wire
